// [tx_desc_map.svh]
/*
 * Constants for the transmit descriptor fetch block: descriptor word
 * layout, register offsets, reset values and frame size figures.
 * Assumes a 32-bit shared memory reached over a simple request/grant port.
 */
// Behaviour
// RL1: Bit 31 of descriptor word 0 says who owns it, 0 for software and 1 for the DMA.
// RL2: Only the owner may write a descriptor; the other party only reads it.
// RL3: A descriptor with the ownership bit at 1 is ready and its frame is sent.
// RL4: When the frame is sent the DMA writes the ownership bit back to 0.
// RL5: Software fills frame and descriptor before it sets the ownership bit to 1.
// RL6: Word 0 bit 2 set makes the DMA raise an interrupt when that frame is done.
// RL7: Word 0 bit 1 set appends a 4-byte CRC to the end of the frame.
// RL8: Word 0 bit 0 set pads a frame shorter than 60 bytes.
// RL9: Word 1 bits 31 to 2 are the word aligned buffer base address.
// RL10: Word 1 bits 1 to 0 are a byte offset added to the base to find the first byte.
// RL11: A descriptor still owned by software is not sent; the DMA polls until released. Here the DMA stops in ST_IDLE until software sets the poll bit.
// RL12: Bits 30 to 3 of word 0 are ignored.
`ifndef TX_DESC_MAP_SVH
`define TX_DESC_MAP_SVH

// ****************************************
// Descriptor layout
// ****************************************
`define W0_OWNER_BIT      31
`define W0_IRQ_EN_BIT     2
`define W0_CRC_EN_BIT     1
`define W0_PAD_EN_BIT     0
`define W1_BASE_MSB       31
`define W1_BASE_LSB       2
`define W1_OFFSET_MSB     1
`define OWNER_DMA         1'b1
`define OWNER_HOST        1'b0
`define MIN_FRAME_BYTES   16'h003c
`define CRC_BYTES         16'h0004

// ****************************************
// Register offsets and reset values
// ****************************************
`define REG_CTRL          4'h0
`define REG_DESC_ADDR     4'h4
`define REG_STATUS        4'h8
`define REG_IRQ_STATUS    4'hc
`define REG_IRQ_MASK      4'h5
`define CTRL_RESET        2'h0
`define IRQ_DONE_BIT      0
`define IRQ_IDLE_BIT      1

`endif

// [tx_desc_pkg.sv]
/*
 * Types for the transmit descriptor fetch block.
 * Assumes tx_desc_map.svh is available for the numeric constants.
 */
`default_nettype none
package tx_desc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RD_W0  = 3'b001,
      ST_RD_W1  = 3'b010,
      ST_RD_W2  = 3'b011,
      ST_SEND   = 3'b100,
      ST_WR_W0  = 3'b101,
      ST_NEXT   = 3'b110
   } dstate_t;
endpackage : tx_desc_pkg
`default_nettype wire

// [ethernet_tx_descriptor_fetch.sv]
/*
 * Transmit descriptor walker: reads word 0, word 1 and the link word of
 * each descriptor, hands frame parameters to the transmitter, writes
 * the ownership bit back and raises the frame done interrupt.
 * Also holds the small register set: control, descriptor address,
 * walk state, sticky interrupt status and interrupt mask.
 *
 * Assumes a memory port that answers a request with a one-cycle grant
 * carrying read data, and a transmitter that pulses frame_sent.
 * Assumes descriptors sit on word boundaries and that the register
 * port never raises read and write strobes together.
 */
`include "tx_desc_map.svh"
`default_nettype none
module ethernet_tx_descriptor_fetch (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   clk_en,
   // Register port
   input  wire logic [3:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   // Memory port
   output logic                        mem_req,
   output logic                        mem_we,
   output logic      [31:0]            mem_addr,
   output logic      [31:0]            mem_wdata,
   input  wire logic                   mem_ack,
   input  wire logic [31:0]            mem_rdata,
   // Transmitter
   output logic                        frame_start,
   output logic      [31:0]            tx_buffer_base,
   output logic      [1:0]             buffer_byte_offset,
   output logic                        checksum_append_enable,
   output logic                        short_frame_fill_enable,
   output logic      [15:0]            min_frame_bytes,
   output logic      [15:0]            crc_bytes,
   input  wire logic                   frame_sent,
   // Interrupt
   output logic                        irq
);
   import tx_desc_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      tx_desc_pkg::dstate_t st;
      logic        enable;
      logic        poll;
      logic [31:0] desc_addr;

      logic [31:0] w0;
      logic [31:0] base;
      logic [1:0]  ofs;
      logic [31:0] link;
      logic        crc_en;
      logic        pad_en;
      logic        irq_en;

      logic [1:0]  irq_status;
      logic [1:0]  irq_mask;
      logic        irq;

      logic [31:0] rdata;

      logic        mem_req;
      logic        mem_we;
      logic [31:0] mem_addr;
      logic [31:0] mem_wdata;
      logic        frame_start;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // ****************************************
   // Descriptor field decode
   // ****************************************
   logic        seen_owner;
   logic        seen_irq_en;
   logic        seen_crc_en;
   logic        seen_pad_en;
   logic [31:0] seen_base;
   logic [1:0]  seen_ofs;
   logic [31:0] seen_link;

   // Word 0 fields
   assign seen_owner = mem_rdata[`W0_OWNER_BIT]; // [RL1]
   assign seen_irq_en = mem_rdata[`W0_IRQ_EN_BIT]; // [RL6]
   assign seen_crc_en = mem_rdata[`W0_CRC_EN_BIT]; // [RL7]
   assign seen_pad_en = mem_rdata[`W0_PAD_EN_BIT]; // [RL8]
   // Word 1 and link word fields
   assign seen_base = {mem_rdata[`W1_BASE_MSB:`W1_BASE_LSB], 2'b00}; // [RL9]
   assign seen_ofs = mem_rdata[`W1_OFFSET_MSB:0]; // [RL10]
   assign seen_link = {mem_rdata[31:2], 2'b00};

   // ****************************************
   // Interrupt events
   // ****************************************
   logic             at_rd_w0;
   logic             at_wr_w0;
   logic             done_event;
   logic             idle_event;
   logic [1:0]       irq_event;
   logic             irq_clear;
   wire logic [1:0]  irq_status_upd;

   assign at_rd_w0 = (s_r.st == ST_RD_W0);
   assign at_wr_w0 = (s_r.st == ST_WR_W0);
   assign done_event = at_wr_w0 && mem_ack
                       && s_r.irq_en; // [RL6]
   assign idle_event = at_rd_w0 && mem_ack
                       && (seen_owner == `OWNER_HOST); // [RL11]
   assign irq_event = {idle_event, done_event};
   assign irq_clear = reg_rd && (reg_addr == `REG_IRQ_STATUS);

   // Set wins over a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq_bit
         assign irq_status_upd[gi] = irq_event[gi] | (s_r.irq_status[gi] & ~irq_clear);
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      s_nxt.frame_start = 1'b0;
      s_nxt.rdata = 32'h0000_0000;

      // ****************************************
      // Register reads
      // ****************************************
      if (reg_rd) begin
         case (reg_addr)
            `REG_CTRL: begin
               s_nxt.rdata = {30'h0, s_r.poll, s_r.enable};
            end
            `REG_DESC_ADDR: begin
               s_nxt.rdata = s_r.desc_addr;
            end
            `REG_STATUS: begin
               s_nxt.rdata = {29'h0, s_r.st};
            end
            `REG_IRQ_STATUS: begin
               s_nxt.rdata = {30'h0, s_r.irq_status};
            end
            `REG_IRQ_MASK: begin
               s_nxt.rdata = {30'h0, s_r.irq_mask};
            end
            default: begin
               s_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (reg_wr) begin
         case (reg_addr)
            `REG_CTRL: begin
               s_nxt.enable = reg_wdata[0];
               s_nxt.poll = reg_wdata[1];
            end
            `REG_DESC_ADDR: begin
               s_nxt.desc_addr = {reg_wdata[31:2], 2'b00};
            end
            `REG_IRQ_MASK: begin
               s_nxt.irq_mask = reg_wdata[1:0];
            end
            default: begin
            end
         endcase
      end

      // ****************************************
      // Descriptor walk
      // ****************************************
      case (s_r.st)
         ST_IDLE: begin
            // Fetch starts only on a poll request [RL11]
            if (s_r.enable && s_r.poll) begin
               s_nxt.poll = 1'b0;
               s_nxt.mem_req = 1'b1;
               s_nxt.mem_we = 1'b0;
               s_nxt.mem_addr = s_r.desc_addr;
               s_nxt.st = ST_RD_W0;
            end
         end
         ST_RD_W0: begin
            if (mem_ack) begin
               s_nxt.w0 = mem_rdata;
               if (seen_owner == `OWNER_DMA) begin // [RL1] [RL3]
                  // Only bits 31, 2, 1 and 0 are used [RL12]
                  s_nxt.irq_en = seen_irq_en;
                  s_nxt.crc_en = seen_crc_en;
                  s_nxt.pad_en = seen_pad_en;
                  s_nxt.mem_req = 1'b1;
                  s_nxt.mem_addr = s_r.desc_addr + 32'h0000_0004;
                  s_nxt.st = ST_RD_W1;
               end else begin
                  // Software still owns it: wait for a poll request [RL11]
                  s_nxt.mem_req = 1'b0;
                  s_nxt.st = ST_IDLE;
               end
            end
         end
         ST_RD_W1: begin
            if (mem_ack) begin
               s_nxt.base = seen_base; // [RL9]
               s_nxt.ofs = seen_ofs; // [RL10]
               s_nxt.mem_req = 1'b1;
               s_nxt.mem_addr = s_r.desc_addr + 32'h0000_000c;
               s_nxt.st = ST_RD_W2;
            end
         end
         ST_RD_W2: begin
            if (mem_ack) begin
               // Link word kept apart so word 0 goes back intact
               s_nxt.link = seen_link;
               s_nxt.mem_req = 1'b0;
               s_nxt.frame_start = 1'b1; // [RL3]
               s_nxt.st = ST_SEND;
            end
         end
         ST_SEND: begin
            if (frame_sent) begin
               s_nxt.mem_req = 1'b1;
               s_nxt.mem_we = 1'b1;
               s_nxt.mem_addr = s_r.desc_addr;
               // Only owner bit changes; other word 0 bits kept [RL2] [RL4]
               s_nxt.mem_wdata = {`OWNER_HOST, s_r.w0[30:0]};
               s_nxt.st = ST_WR_W0;
            end
         end
         ST_WR_W0: begin
            if (mem_ack) begin
               s_nxt.mem_req = 1'b0;
               s_nxt.mem_we = 1'b0;
               s_nxt.st = ST_NEXT;
            end
         end
         ST_NEXT: begin
            s_nxt.desc_addr = s_r.link;
            s_nxt.poll = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase

      // ****************************************
      // Interrupt status and line
      // ****************************************
      s_nxt.irq_status = irq_status_upd; // [RL6]
      s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
   end

   // ****************************************
   // State register
   // ****************************************

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Register port outputs
   // ****************************************
   assign reg_rdata = s_r.rdata;

   // ****************************************
   // Memory port outputs
   // ****************************************
   assign mem_req = s_r.mem_req;
   assign mem_we = s_r.mem_we;
   assign mem_addr = s_r.mem_addr;
   assign mem_wdata = s_r.mem_wdata;

   // ****************************************
   // Transmitter outputs
   // ****************************************
   assign frame_start = s_r.frame_start;
   assign tx_buffer_base = s_r.base;
   assign buffer_byte_offset = s_r.ofs;
   assign checksum_append_enable = s_r.crc_en; // [RL7]
   assign short_frame_fill_enable = s_r.pad_en; // [RL8]
   assign min_frame_bytes = `MIN_FRAME_BYTES; // [RL8]
   assign crc_bytes = `CRC_BYTES; // [RL7]

   // ****************************************
   // Interrupt output
   // ****************************************
   assign irq = s_r.irq;
endmodule : ethernet_tx_descriptor_fetch
`default_nettype wire

// [txdf_chk.sv]
/* Port assertions for the descriptor fetch block.
   Assumes binding onto the top module. */
`default_nettype none
module txdf_chk (
   // Watched ports
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic        mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic        frame_start,
   input wire logic [31:0] tx_buffer_base,
   input wire logic [15:0] min_frame_bytes,
   input wire logic [15:0] crc_bytes
);
   // ****
   // Relations
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   size_const_a: assert property (min_frame_bytes == 16'h003c && crc_bytes == 16'h0004)
      else $error("size");
   base_align_a: assert property (frame_start |-> tx_buffer_base[1:0] == 2'h0)
      else $error("base");
   start_pulse_a: assert property (frame_start |=> !frame_start)
      else $error("start");
   owner_back_a: assert property (mem_req && mem_we |-> !mem_wdata[31])
      else $error("owner");
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("req");
   word_addr_a: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
      else $error("addr");
   host_wait_a: assert property (mem_req && mem_ack && !mem_we && mem_addr[3:0] == 4'h0
      && !mem_rdata[31] |-> ##1 !frame_start [*4]) else $error("host");
   rdata_idle_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
      else $error("rdata");
endmodule : txdf_chk
bind ethernet_tx_descriptor_fetch txdf_chk u_chk (.*);
`default_nettype wire

// [txdf_mem.sv]
/* Shared memory holding descriptors.
   Assumes one request held until granted. */
`default_nettype none
module txdf_mem (
   // Memory port
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [1:0]  lat,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata
);
   logic [31:0] m [0:63];
   logic [1:0]  wait_r;
   // ****
   // Grant lat+1 cycles after mem_req rises
   // ****
   always @(posedge clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (reset) begin
         wait_r <= 2'h0;
         mem_rdata <= 32'h0;
      end else if (mem_req && !mem_ack) begin
         wait_r <= wait_r + 2'h1;
         if (wait_r == lat) begin
            wait_r <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_we) begin
               m[mem_addr[7:2]] <= mem_wdata;
            end else begin
               mem_rdata <= m[mem_addr[7:2]];
            end
         end
      end
   end
endmodule : txdf_mem
`default_nettype wire

// [ethernet_tx_descriptor_fetch_tb.sv]
/* Bench for the descriptor fetch block.
   Assumes txdf_mem as memory and txdf_chk bound. */
`default_nettype none
`define CHK(n, e, v) begin n_tests++; if ((v) !== (e)) begin err_count++; \
   $display("ERROR %s exp %h got %h", n, e, v); end end
module ethernet_tx_descriptor_fetch_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, frame_sent = 0, en = 1;
   logic mem_req, mem_we, mem_ack, frame_start, crc, pad, irq;
   logic [3:0]  reg_addr = 4'h0;
   logic [1:0]  lat = 2'h3, off;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata, mem_rdata, base;
   int err_count = 0, n_tests = 0, cyc = 0;
   ethernet_tx_descriptor_fetch DUT (.clk(clk), .reset(reset), .clk_en(en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .frame_start(frame_start), .tx_buffer_base(base), .buffer_byte_offset(off),
      .checksum_append_enable(crc), .short_frame_fill_enable(pad),
      .min_frame_bytes(), .crc_bytes(), .frame_sent(frame_sent), .irq(irq));
   txdf_mem u_mem (.clk(clk), .reset(reset), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         test_done;
      end
   end
   // ****
   // Tasks
   // ****
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 `CHK(n, e, reg_rdata)
   endtask : rd
   task automatic frame(input logic [31:0] b, input logic [1:0] o, input logic c, p, int w);
      do @(negedge clk); while (frame_start !== 1'b1);
      `CHK("base", b, base)
      `CHK("offset", o, off)
      `CHK("crc", c, crc)
      `CHK("pad", p, pad)
      `CHK("irq early", 1'b0, irq)
      repeat (4) @(posedge clk);
      frame_sent <= 1'b1;
      @(posedge clk);
      frame_sent <= 1'b0;
      do @(negedge clk); while (!(mem_ack && mem_we));
      repeat (2) @(negedge clk);
      `CHK("owner", 1'b0, u_mem.m[w][31])
   endtask : frame
   task automatic t_chain;
      wr(4'h5, 32'h3);
      wr(4'h4, 32'h0);
      wr(4'h0, 32'h3);
      frame(32'h100, 2'h1, 1'b1, 1'b0, 0);
      `CHK("w0 kept", 32'h7ffffffe, u_mem.m[0])
      `CHK("irq set", 1'b1, irq)
      rd(4'hc, 32'h1, "status");
      wr(4'h5, 32'h1);
      frame(32'h1000, 2'h3, 1'b0, 1'b1, 8);
      `CHK("w0 reserved kept", 32'h2aaaaaa9, u_mem.m[8])
      do @(negedge clk); while (!(mem_ack && mem_addr === 32'h40));
      repeat (3) @(negedge clk);
      `CHK("irq masked", 1'b0, irq)
      rd(4'hc, 32'h2, "host owned");
   endtask : t_chain
   task automatic t_release;
      `CHK("irq clear", 1'b0, irq)
      u_mem.m[16] = 32'h80000006;
      lat = 2'h0;
      @(posedge clk);
      en <= 1'b0;
      wr(4'h0, 32'h3);
      repeat (4) @(negedge clk);
      `CHK("frozen", 1'b0, mem_req)
      @(posedge clk);
      en <= 1'b1;
      wr(4'h0, 32'h3);
      frame(32'ha000, 2'h0, 1'b1, 1'b0, 16);
      `CHK("irq again", 1'b1, irq)
      rd(4'h2, 32'h0, "unmapped");
   endtask : t_release
   task automatic test_done;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   initial begin
      u_mem.m[0] = 32'hfffffffe;
      u_mem.m[1] = 32'h00000101;
      u_mem.m[3] = 32'h00000020;
      u_mem.m[8] = 32'haaaaaaa9;
      u_mem.m[9] = 32'h00001003;
      u_mem.m[11] = 32'h00000040;
      u_mem.m[16] = 32'h00000006;
      u_mem.m[17] = 32'h0000a000;
      u_mem.m[19] = 32'h00000000;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_chain;
      t_release;
      test_done;
   end
endmodule : ethernet_tx_descriptor_fetch_tb
`default_nettype wire
